// ==== flpm_core.sv ====
// Four-level packet modem core: host bus, block buffer, CRC, FEC,
// interleave, frame sync, symbol timing and level tracking.
// Assumes host pins and the received sample arrive asynchronously.
// Operation
// - Drive data bus only during selected read.
// - Select, strobes and register selects govern transfers.
// - Twelve-byte data buffer for both directions.
// - Generate CRC on transmit, check on receive.
// - FEC encode to symbols, decode with parity error detection.
// - Interleave and de-interleave symbols within blocks.
// - Search frame sync only in receive mode.
// - Receive mode output bias, or eye signal.
// - Bias for eight symbols entering transmit.
// - Receive-only clock recovery and level tracking.
// - Symbol rate divided down from reference clock.
// - Frame is preamble then formatted blocks.
// - Host loads buffer, commands; device formats, sends.
// - Receive task collects, decodes, checks, fills buffer.
// - Unformatted four, twenty-four and receive-four tasks.
// - Dibit map: 11,10,00,01 to +3,+1,-1,-3.
// - Byte becomes four symbols and back.
// - Block tasks code three bits per symbol pair.
// - Frame carries header, intermediate or last blocks.
// - Register selects choose four write, three read.
// - Task clears buffer free; transfer sets it, interrupts.
// - Checksum select: ones when 0, zeros when 1.
//
// Added by the designer: the address map and strobed register access.
`timescale 1ns/1ps
`default_nettype none
module flpm_core #(
  parameter int          SYM_DIV = flpm_pkg::SYM_CLKS,
  parameter logic [47:0] FSYNC   = flpm_pkg::FSYNC_PAT
) (
  input  wire logic              ref_clk_in,
  input  wire logic              rst_in,
  input  wire logic              device_select_n_in,
  input  wire logic              write_strobe_n_in,
  input  wire logic              read_strobe_n_in,
  input  wire logic              reg_select_lo_in,
  input  wire logic              reg_select_hi_in,
  input  wire logic [7:0]        data_in,
  output logic      [7:0]        data_out,
  output logic                   data_oe_out,
  output logic                   interrupt_out_n,
  output logic                   interrupt_oe_out,
  input  wire logic signed [7:0] rx_sample_in,
  output logic signed [7:0]      tx_signal_out
);
  import flpm_pkg::*;
  localparam int DW = $clog2(SYM_DIV);

  function automatic logic [15:0] crc_byte(input logic [15:0] c,
                                           input logic [7:0]  b);
    logic [15:0] r;
    r = c;
    for (int i = 7; i >= 0; i--) begin
      r = {r[14:0], 1'b0} ^ ((r[15] ^ b[i]) ? CRC_POLY : CRC_ZERO);
    end
    return r;
  endfunction

  function automatic logic signed [7:0] lvl(input logic [1:0] d);
    case (d)
      2'h3:    lvl = LVL_P3;
      2'h2:    lvl = LVL_P1;
      2'h0:    lvl = LVL_M1;
      default: lvl = LVL_M3;
    endcase
  endfunction

  logic [12:0]       hs1, hs2;
  logic signed [7:0] rx1, rx2;
  logic              wr_act, rd_act;
  logic [1:0]        acc_sel;
  logic [7:0]        wr_dat, cmd_reg, ctl_reg, mode_reg;
  logic [3:0]        hptr, idx, bias_cnt;
  logic [7:0]        dbuf [BLK_BYTES];
  logic [1:0]        sym  [BLK_SYMS];
  logic [95:0]       blk;
  flpm_eng_t         eng;
  logic [2:0]        task_q;
  logic [15:0]       crc_run, crc2;
  logic [5:0]        rcnt, tcnt, tx_len;
  logic              crc_sel, srch, buffer_free_flag, irq, crc_err, fec_err;
  logic              sync_found, tx_go, tx_busy, tx_il, mode_q, sgn_q;
  logic [DW-1:0]     sym_cnt;
  logic signed [7:0] dc;
  logic signed [8:0] amp;
  logic [4:0]        aq_cnt;
  logic [47:0]       rx_hist;
  logic [1:0]        fec_sym [BLK_SYMS];
  logic [1:0]        load_sym [BLK_SYMS];
  logic [95:0]       dec_flat;
  logic [31:0]       par_bad;

  // Two-stage synchronisers for host pins and the received sample.
  // Host pin synchronising.
  wire logic [12:0] h_raw = {device_select_n_in, write_strobe_n_in,
                             read_strobe_n_in, reg_select_hi_in,
                             reg_select_lo_in, data_in};
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      hs1 <= HOST_IDLE;
      hs2 <= HOST_IDLE;
      rx1 <= LVL_BIAS;
      rx2 <= LVL_BIAS;
    end else begin
      hs1 <= h_raw;
      hs2 <= hs1;
      rx1 <= rx_sample_in;
      rx2 <= rx1;
    end
  end

  wire logic       cs_n = hs2[12];
  wire logic       wr_n = hs2[11];
  wire logic       rd_n = hs2[10];
  wire logic [1:0] rsel = hs2[9:8];
  wire logic       wr_done = wr_act & wr_n;
  wire logic       rd_done = rd_act & rd_n;

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      wr_act  <= 1'b0;
      rd_act  <= 1'b0;
      acc_sel <= SEL_DATA;
      wr_dat  <= REG_RST;
    end else begin
      wr_act <= !cs_n & !wr_n;
      rd_act <= !cs_n & !rd_n;
      if (!cs_n & !wr_n) wr_dat <= hs2[7:0];
      if (!cs_n & (!wr_n | !rd_n)) acc_sel <= rsel;
    end
  end

  wire logic we_buf  = wr_done & (acc_sel == SEL_DATA);
  wire logic we_cmd  = wr_done & (acc_sel == SEL_CMD);
  wire logic we_ctl  = wr_done & (acc_sel == SEL_CTL);
  wire logic we_mode = wr_done & (acc_sel == SEL_MODE);
  wire logic re_buf  = rd_done & (acc_sel == SEL_DATA);
  wire logic re_stat = rd_done & (acc_sel == SEL_CMD);
  wire logic tx_mode = mode_reg[MODE_TX];
  wire logic [2:0] task_w = wr_dat[2:0];
  wire logic task_rst = we_cmd & (task_w == TASK_RESET);
  wire logic task_go  = we_cmd & (task_w != TASK_RESET)
                        & (task_w != TASK_NULL);
  wire logic unf_q = (task_q == TASK_FOUR_SYM)
                     | (task_q == TASK_TWENTYFOUR)
                     | (task_q == TASK_RX_FOUR_SYM);
  wire logic crc_app = tx_mode & ((task_q == TASK_HEADER_BLOCK)
                                  | (task_q == TASK_LAST_BLOCK));
  wire logic [15:0] crc_init = crc_sel ? CRC_ZERO : CRC_ONES;

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      cmd_reg  <= REG_RST;
      ctl_reg  <= REG_RST;
      mode_reg <= REG_RST;
      mode_q   <= 1'b0;
    end else begin
      if (we_cmd) cmd_reg <= wr_dat;
      if (we_ctl) ctl_reg <= wr_dat;
      if (we_mode) mode_reg <= wr_dat;
      mode_q <= tx_mode;
    end
  end

  wire logic tick = sym_cnt == DW'(SYM_DIV - 1);
  wire logic signed [8:0] d_now = 9'(rx2) - 9'(dc);
  wire logic signed [8:0] mag = d_now[8] ? -d_now : d_now;
  wire logic resync = !tx_mode & (d_now[8] != sgn_q);
  wire logic [2:0] sh = (aq_cnt != 5'h00) ? 3'h1 : 3'(LEV_SHIFT);
  wire logic [1:0] sliced = (d_now >= amp) ? 2'h3 :
                            !d_now[8] ? 2'h2 :
                            (d_now > -amp) ? 2'h0 : 2'h1;
  wire logic aq_go = we_cmd & !task_rst & !tx_mode & wr_dat[CMD_AQLEV];

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      sym_cnt <= '0;
      sgn_q   <= 1'b0;
      dc      <= LVL_BIAS;
      amp     <= AMP_RST;
      aq_cnt  <= 5'h00;
      rx_hist <= '0;
    end else begin
      sgn_q <= d_now[8];
      if (resync) sym_cnt <= DW'(SYM_DIV / 2);
      else if (tick) sym_cnt <= '0;
      else sym_cnt <= sym_cnt + 1'b1;
      if (aq_go) aq_cnt <= 5'(AQ_SYMS);
      else if (tick && aq_cnt != 5'h00) aq_cnt <= aq_cnt - 1'b1;
      if (tick && !tx_mode) begin
        dc      <= 8'(9'(dc) + (d_now >>> sh));
        amp     <= amp + ((mag - amp) >>> sh);
        rx_hist <= {rx_hist[45:0], sliced};
      end
    end
  end

  wire logic sync_hit = {rx_hist[45:0], sliced} == FSYNC;

  // Three bits to two symbols with parity, and back.
  for (genvar k = 0; k < 32; k++) begin : g_fec
    wire logic [2:0] t = blk[95-3*k -: 3];
    assign fec_sym[2*k]   = t[2:1];
    assign fec_sym[2*k+1] = {t[0], ^t};
    assign dec_flat[95-3*k -: 3] = {sym[2*k], sym[2*k+1][1]};
    assign par_bad[k] = ^{sym[2*k], sym[2*k+1]};
  end
  for (genvar k = 0; k < BLK_SYMS; k++) begin : g_load
    localparam int DB = (k < 48) ? 95 - 2 * k : 1;
    assign load_sym[k] = unf_q ? blk[DB -: 2] : fec_sym[k];
  end

  wire logic [5:0] rx_addr = unf_q ? rcnt : {rcnt[2:0], rcnt[5:3]};
  wire logic [5:0] taddr = tx_il ? {tcnt[2:0], tcnt[5:3]} : tcnt;
  wire logic [5:0] rlen = unf_q ? 6'(FOUR_SYMS - 1) : 6'(BLK_SYMS - 1);
  wire logic rx_store = (eng == E_WAIT) & !tx_mode & tick & !srch;
  wire logic x_start = (eng == E_WAIT) & (tx_mode ? !tx_busy & !tx_go
                                          : rx_store & (rcnt == rlen));
  wire logic last_x = idx == 4'(BLK_BYTES - 1);
  wire logic [7:0] rx_byte = unf_q ? {sym[0], sym[1], sym[2], sym[3]}
                                   : dec_flat[95-8*idx -: 8];
  wire logic [7:0] tx_byte = (crc_app && idx >= 4'ha)
                             ? (idx == 4'ha ? crc_run[15:8] : crc_run[7:0])
                             : dbuf[idx];
  wire logic [7:0] x_byte = tx_mode ? tx_byte : rx_byte;
  wire logic crc_on = !(crc_app && idx >= 4'ha);

  always_ff @(posedge ref_clk_in) begin
    if (eng == E_XFER && !tx_mode) dbuf[idx] <= x_byte;
    // Host writes assume the buffer is free.
    else if (we_buf && tx_mode) dbuf[hptr] <= wr_dat;
    if (eng == E_XFER) blk[95-8*idx -: 8] <= x_byte;
    if (eng == E_LOAD && tx_mode) begin
      for (int k = 0; k < BLK_SYMS; k++) sym[k] <= load_sym[k];
    end else if (rx_store) sym[rx_addr] <= sliced;
  end

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      eng <= E_IDLE;
      task_q <= TASK_NULL;
      idx <= 4'h0;
      rcnt <= 6'h00;
      crc_run <= CRC_ONES;
      crc2 <= CRC_ONES;
      crc_sel <= 1'b0;
      srch <= 1'b0;
      buffer_free_flag <= 1'b1;
      irq <= 1'b0;
      crc_err <= 1'b0;
      fec_err <= 1'b0;
      sync_found <= 1'b0;
      tx_go <= 1'b0;
      tx_len <= 6'h00;
      tx_il <= 1'b0;
    end else begin
      tx_go <= 1'b0;
      if (re_stat) irq <= 1'b0;
      if (srch && tx_mode) srch <= 1'b0;
      if (task_rst) begin
        eng <= E_IDLE;
        buffer_free_flag <= 1'b1;
        srch <= 1'b0;
      end else begin
        case (eng)
          E_IDLE: begin
            if (task_go) begin
              eng <= E_WAIT;
              task_q <= task_w;
              buffer_free_flag <= 1'b0;
              rcnt <= 6'h00;
              crc_sel <= wr_dat[CMD_CRC];
              srch <= !tx_mode && task_w == TASK_HEADER_BLOCK;
            end
          end
          E_WAIT: begin
            if (srch && tick && sync_hit) begin
              srch <= 1'b0;
              sync_found <= 1'b1;
            end
            if (rx_store) rcnt <= rcnt + 1'b1;
            if (x_start) begin
              eng <= E_XFER;
              idx <= 4'h0;
              crc_run <= (task_q == TASK_HEADER_BLOCK) ? crc_init : crc2;
            end
          end
          E_XFER: begin
            if (crc_on) crc_run <= crc_byte(crc_run, x_byte);
            idx <= idx + 1'b1;
            if (last_x) eng <= E_LOAD;
          end
          default: begin
            eng <= E_IDLE;
            // Transfer done sets buffer free and interrupt.
            buffer_free_flag <= 1'b1;
            irq <= 1'b1;
            if (task_q == TASK_HEADER_BLOCK) crc2 <= crc_init;
            if (task_q == TASK_INTER_BLOCK) crc2 <= crc_run;
            if (tx_mode) begin
              tx_go <= 1'b1;
              tx_il <= !unf_q;
              tx_len <= (task_q == TASK_FOUR_SYM) ? 6'(FOUR_SYMS - 1) :
                        (task_q == TASK_TWENTYFOUR) ? 6'(SYNC_SYMS - 1) :
                        6'(BLK_SYMS - 1);
            end else if (!unf_q) begin
              crc_err <= crc_run != CRC_ZERO;
              fec_err <= |par_bad;
            end
          end
        endcase
      end
    end
  end

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) hptr <= 4'h0;
    else if (task_go || task_rst || eng == E_LOAD) hptr <= 4'h0;
    else if ((we_buf && tx_mode) || re_buf)
      hptr <= (hptr == 4'(BLK_BYTES - 1)) ? 4'h0 : hptr + 1'b1;
  end

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      bias_cnt <= 4'h0;
      tx_busy <= 1'b0;
      tcnt <= 6'h00;
      tx_signal_out <= LVL_BIAS;
    end else begin
      if (tx_mode && !mode_q) bias_cnt <= 4'(BIAS_SYMS);
      else if (tick && bias_cnt != 4'h0) bias_cnt <= bias_cnt - 1'b1;
      if (!tx_mode || task_rst) tx_busy <= 1'b0;
      else if (tx_go) begin
        tx_busy <= 1'b1;
        tcnt <= 6'h00;
      end else if (tick && tx_busy && bias_cnt == 4'h0) begin
        tcnt <= tcnt + 1'b1;
        if (tcnt == tx_len) tx_busy <= 1'b0;
      end
      if (!tx_mode) tx_signal_out <= ctl_reg[CTL_EYE] ? rx2 : LVL_BIAS;
      else if (tick || !mode_q)
        tx_signal_out <= (tx_busy && bias_cnt == 4'h0) ? lvl(sym[taddr])
                                                       : LVL_BIAS;
    end
  end

  wire logic [7:0] status = {buffer_free_flag, irq, crc_err, sync_found,
                             fec_err, 3'h0};
  wire logic [7:0] rd_mux = (rsel == SEL_DATA) ? dbuf[hptr] :
                            (rsel == SEL_CMD) ? status :
                            (rsel == SEL_CTL) ? amp[7:0] : 8'h00;
  wire logic irq_drive = irq & mode_reg[MODE_IRQEN];

  // Bus drive only while selected read.
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      data_out <= 8'h00;
      data_oe_out <= 1'b0;
      interrupt_out_n <= 1'b1;
      interrupt_oe_out <= 1'b0;
    end else begin
      data_out <= rd_mux;
      data_oe_out <= !cs_n & !rd_n;
      interrupt_out_n <= !irq_drive;
      interrupt_oe_out <= irq_drive;
    end
  end

  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);

  a_bus_drive_read: assert property (
    data_oe_out |-> $past(!cs_n && !rd_n)) else $error("bus driven idle");
  a_write_on_release: assert property (
    we_cmd |-> wr_n && $past(!wr_n)) else $error("write not on release");
  a_task_clears_free: assert property (
    (eng == E_IDLE && task_go && !task_rst) |=> !buffer_free_flag ##1 !buffer_free_flag)
    else $error("buffer free not cleared");
  a_load_sets_free: assert property (
    (eng == E_LOAD && !task_rst) |=> buffer_free_flag && irq && eng == E_IDLE)
    else $error("buffer free not set");
  a_bias_eight: assert property (
    (tx_mode && !mode_q) |=> bias_cnt == 4'h8) else $error("bias count");
  a_bias_out_held: assert property (
    (tx_mode && mode_q && bias_cnt != 4'h0)
    |=> tx_signal_out == LVL_BIAS) else $error("symbol during bias");
  a_rx_bias_level: assert property (
    (!tx_mode && !ctl_reg[CTL_EYE]) |=> tx_signal_out == LVL_BIAS)
    else $error("rx output not bias");
  a_eye_follows: assert property (
    (!tx_mode && ctl_reg[CTL_EYE]) |=> tx_signal_out == $past(rx2))
    else $error("eye not routed");
  a_crc_start: assert property (
    (x_start && task_q == TASK_HEADER_BLOCK && !task_rst)
    |=> crc_run == (crc_sel ? CRC_ZERO : CRC_ONES))
    else $error("crc start value");
  a_search_rx_only: assert property (
    (srch && tx_mode) |=> !srch) else $error("search in tx");
  a_block_len: assert property (
    (eng == E_XFER && idx == 4'h0 && !task_rst) |-> ##11 eng == E_XFER
    ##1 eng == E_LOAD) else $error("block length");

  c_tx_block: cover property (eng == E_LOAD && tx_mode && !unf_q);
  c_rx_block: cover property (eng == E_LOAD && !tx_mode && !unf_q);
  c_sync_hit: cover property (srch ##1 !srch && eng == E_WAIT);
endmodule // flpm_core
`default_nettype wire

// ==== flpm_host_model.sv ====
// Host bus model for the four-level packet modem core.
// Assumes one clock; pins change only just after a rising edge.
`timescale 1ns/1ps
`default_nettype none
module flpm_host_model (
  input  wire logic       clk_in,
  input  wire logic [7:0] rd_data_in,
  input  wire logic       rd_oe_in,
  output logic            cs_n_out,
  output logic            wr_n_out,
  output logic            rd_n_out,
  output logic [1:0]      sel_out,
  output logic [7:0]      bus_out
);
  logic [7:0] wdat;
  logic       drive;
  assign bus_out = rd_oe_in ? rd_data_in : (drive ? wdat : ~wdat);
  initial begin
    cs_n_out = 1'b1;
    wr_n_out = 1'b1;
    rd_n_out = 1'b1;
    sel_out  = 2'h0;
    wdat     = 8'h00;
    drive    = 1'b0;
  end
  task automatic wr(input logic [1:0] s, input logic [7:0] d);
    sel_out  <= s;
    wdat     <= d;
    drive    <= 1'b1;
    cs_n_out <= 1'b0;
    wr_n_out <= 1'b0;
    repeat (4) @(posedge clk_in);
    cs_n_out <= 1'b1;
    wr_n_out <= 1'b1;
    repeat (4) @(posedge clk_in);
    drive <= 1'b0;
    @(posedge clk_in);
  endtask
  task automatic rd(input logic [1:0] s);
    int n;
    sel_out  <= s;
    cs_n_out <= 1'b0;
    rd_n_out <= 1'b0;
    n = 0;
    do begin
      @(posedge clk_in);
      n++;
    end while (rd_oe_in !== 1'b1 && n < 10);
    cs_n_out <= 1'b1;
    rd_n_out <= 1'b1;
    repeat (5) @(posedge clk_in);
  endtask
endmodule // flpm_host_model
`default_nettype wire

// ==== flpm_pkg.sv ====
// Constants shared by the four-level packet modem core.
// Assumes one 200 MHz clock and a byte-wide asynchronous host bus.
`default_nettype none
package flpm_pkg;
  localparam int CLK_HZ    = 200000000;
  localparam int SYM_HZ    = 9600;
  localparam int SYM_CLKS  = CLK_HZ / SYM_HZ;
  localparam int BLK_BYTES = 12;
  localparam int BLK_SYMS  = 64;
  localparam int SYNC_SYMS = 24;
  localparam int BIAS_SYMS = 8;
  localparam int FOUR_SYMS = 4;
  localparam int LEV_SHIFT = 4;
  localparam int AQ_SYMS   = 16;
  // Register select codes {reg_select_hi, reg_select_lo}.
  localparam logic [1:0] SEL_DATA = 2'h0;
  localparam logic [1:0] SEL_CMD  = 2'h1;
  localparam logic [1:0] SEL_CTL  = 2'h2;
  localparam logic [1:0] SEL_MODE = 2'h3;
  // Bit positions.
  localparam int ST_BUFFER_FREE_FLAG   = 7;
  localparam int ST_IRQ     = 6;
  localparam int ST_CRCERR  = 5;
  localparam int ST_SYNC    = 4;
  localparam int ST_FECERR  = 3;
  localparam int CMD_AQSC   = 7;
  localparam int CMD_AQLEV  = 6;
  localparam int CMD_CRC    = 5;
  localparam int MODE_TX    = 7;
  localparam int MODE_IRQEN = 6;
  localparam int CTL_EYE    = 0;
  // Task codes.
  localparam logic [2:0] TASK_NULL         = 3'h0;
  localparam logic [2:0] TASK_HEADER_BLOCK = 3'h1;
  localparam logic [2:0] TASK_INTER_BLOCK  = 3'h2;
  localparam logic [2:0] TASK_LAST_BLOCK   = 3'h3;
  localparam logic [2:0] TASK_FOUR_SYM     = 3'h4;
  localparam logic [2:0] TASK_TWENTYFOUR   = 3'h5;
  localparam logic [2:0] TASK_RX_FOUR_SYM  = 3'h6;
  localparam logic [2:0] TASK_RESET        = 3'h7;
  // Reset values, CRC polynomial and sync pattern.
  localparam logic [7:0]  REG_RST   = 8'h00;
  localparam logic [12:0] HOST_IDLE = 13'h1c00;
  localparam logic [8:0]  AMP_RST   = 9'h020;
  localparam logic [15:0] CRC_POLY  = 16'h1021;
  localparam logic [15:0] CRC_ONES  = 16'hffff;
  localparam logic [15:0] CRC_ZERO  = 16'h0000;
  localparam logic [47:0] FSYNC_PAT = 48'h3a5c_96f0_e21b;
  // Output levels around the bias point.
  localparam logic signed [7:0] LVL_BIAS = 8'h00;
  localparam logic signed [7:0] LVL_P3   = 8'h60;
  localparam logic signed [7:0] LVL_P1   = 8'h20;
  localparam logic signed [7:0] LVL_M1   = 8'he0;
  localparam logic signed [7:0] LVL_M3   = 8'ha0;
  typedef enum logic [1:0] {E_IDLE, E_WAIT, E_XFER, E_LOAD} flpm_eng_t;
endpackage
`default_nettype wire

// ==== four_level_packet_modem_core_test.sv ====
// Self-checking bench for the four-level packet modem core.
// Assumes the host model drives the bus and a short symbol divider.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin \
  checked++; \
  if ((g) !== (e)) begin \
    err_count++; \
    $display("BAD %s exp %h got %h", n, e, g); \
  end \
end
module four_level_packet_modem_core_test;
  import flpm_pkg::*;
  localparam int DIV = 8;
  logic                ref_clk_in = 1'b0;
  logic                rst_in = 1'b1;
  logic                cs_n;
  logic                wr_n;
  logic                rd_n;
  logic [1:0]          sel;
  logic [7:0]          bus;
  logic [7:0]          dout;
  logic                doe;
  logic                irq_n;
  logic                irq_oe;
  logic signed [7:0]   rx = 8'h00;
  logic signed [7:0]   tx;
  logic [7:0]          rd_q[$];
  logic signed [7:0]   sym_q[$];
  logic [7:0]          exp_rd;
  logic                prev_oe = 1'b0;
  logic                first_burst = 1'b1;
  int                  err_count = 0;
  int                  checked = 0;
  int                  cyc = 0;
  int                  mode_cyc = 0;
  always #2.5 ref_clk_in = ~ref_clk_in;
  flpm_host_model host (.clk_in(ref_clk_in), .rd_data_in(dout),
    .rd_oe_in(doe), .cs_n_out(cs_n), .wr_n_out(wr_n), .rd_n_out(rd_n),
    .sel_out(sel), .bus_out(bus));
  flpm_core #(.SYM_DIV(DIV)) uut (.ref_clk_in(ref_clk_in),
    .rst_in(rst_in), .device_select_n_in(cs_n), .write_strobe_n_in(wr_n),
    .read_strobe_n_in(rd_n), .reg_select_lo_in(sel[0]),
    .reg_select_hi_in(sel[1]), .data_in(bus), .data_out(dout),
    .data_oe_out(doe), .interrupt_out_n(irq_n),
    .interrupt_oe_out(irq_oe), .rx_sample_in(rx), .tx_signal_out(tx));
  task automatic give_verdict;
    if (err_count == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  always @(posedge ref_clk_in) begin
    cyc <= cyc + 1;
    if (cyc >= 20000) begin
      err_count++;
      give_verdict();
    end
  end
  always @(posedge ref_clk_in) begin
    prev_oe <= doe;
    if (doe === 1'b1 && prev_oe !== 1'b1 && rd_q.size() > 0) begin
      exp_rd = rd_q.pop_front();
      `CHK("read", exp_rd, dout)
    end
  end
  initial begin : sym_mon
    logic signed [7:0] e;
    forever begin
      @(posedge ref_clk_in);
      if (tx !== 8'h00 && sym_q.size() > 0) begin
        if (first_burst) `CHK("bias", 1'b1, (cyc - mode_cyc) >= 7 * DIV)
        first_burst = 1'b0;
        repeat (DIV / 2) @(posedge ref_clk_in);
        while (sym_q.size() > 0) begin
          e = sym_q.pop_front();
          `CHK("sym", e, tx)
          repeat (DIV) @(posedge ref_clk_in);
        end
      end
    end
  end
  function automatic logic signed [7:0] lvl(input logic [1:0] d);
    case (d)
      2'b11: return LVL_P3;
      2'b10: return LVL_P1;
      2'b00: return LVL_M1;
      default: return LVL_M3;
    endcase
  endfunction
  task automatic push_byte(input logic [7:0] b);
    for (int k = 3; k >= 0; k--) begin
      sym_q.push_back(lvl(b[2*k+:2]));
    end
  endtask
  task automatic irq_seq;
    int n;
    for (n = 0; n < 2000 && irq_oe !== 1'b1; n++) begin
      @(posedge ref_clk_in);
    end
    `CHK("irq_pin", 1'b0, irq_n)
    rd_q.push_back(8'hc0);
    host.rd(SEL_CMD);
    rd_q.push_back(8'h80);
    host.rd(SEL_CMD);
    repeat (2) @(posedge ref_clk_in);
    `CHK("irq_off", 1'b0, irq_oe)
  endtask
  task automatic drain;
    int n;
    for (n = 0; n < 3000 && sym_q.size() > 0; n++) begin
      @(posedge ref_clk_in);
    end
    repeat (2 * DIV) @(posedge ref_clk_in);
  endtask
  initial begin
    logic [7:0] b;
    void'($urandom(32'hb92f));
    repeat (6) @(posedge ref_clk_in);
    rst_in <= 1'b0;
    repeat (3) @(posedge ref_clk_in);
    `CHK("oe_rst", 1'b0, doe)
    `CHK("tx_rst", LVL_BIAS, tx)
    `CHK("irq_rst", 1'b0, irq_oe)
    rd_q.push_back(8'h80);
    host.rd(SEL_CMD);
    rd_q.push_back(8'h00);
    host.rd(SEL_MODE);
    rx <= 8'($urandom_range(127, 1));
    host.wr(SEL_CTL, 8'h01);
    repeat (8) @(posedge ref_clk_in);
    `CHK("eye", rx, tx)
    host.wr(SEL_CTL, 8'h00);
    repeat (8) @(posedge ref_clk_in);
    `CHK("rx_bias", LVL_BIAS, tx)
    host.wr(SEL_MODE, 8'hc0);
    mode_cyc = cyc;
    b = 8'($urandom);
    push_byte(b);
    host.wr(SEL_DATA, b);
    host.wr(SEL_CMD, {5'h00, TASK_FOUR_SYM});
    irq_seq();
    drain();
    for (int i = 0; i < 6; i++) begin
      b = 8'hf5;
      push_byte(b);
      host.wr(SEL_DATA, b);
    end
    host.wr(SEL_CMD, {5'h00, TASK_TWENTYFOUR});
    irq_seq();
    drain();
    give_verdict();
  end
endmodule // four_level_packet_modem_core_test
`default_nettype wire
